// file: hw/buck_sequencer.sv
// Charge sequencer for a single-inductor four-output buck converter.
// Assumes comparators and current sense are synchronous to MCLK, and SLEEP_TICK is
// a one-cycle pulse per sleep clock tick.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module buck_sequencer
	import buck_pkg::*;
(
	// Clock and reset.
	input wire logic MCLK,
	input wire logic RST,
	// Register port.
	input wire logic [buck_pkg::ADDR_W-1:0] ADDR,
	input wire logic [buck_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [buck_pkg::DATA_W-1:0] RDATA,
	// Analog sense.
	input wire logic [buck_pkg::NOUT-1:0] RAIL_LOW,
	input wire logic CUR_AT_LIMIT,
	input wire logic CUR_ZERO,
	input wire logic BUS_ABOVE_BAT,
	input wire logic SLEEP_TICK,
	// Power switch controls.
	output logic SW_BAT,
	output logic SW_GND,
	output logic [buck_pkg::NOUT-1:0] SW_OUT,
	output logic [buck_pkg::LIM_W-1:0] CUR_LIMIT,
	// Regulator controls.
	output logic LINEAR_HANDOVER,
	output logic BUS_REG_EN,
	output logic HOLD_REG_ACTIVE,
	output logic BANDGAP_EN,
	output logic HOLD_SAMPLE,
	// Interrupt.
	output logic IRQ
);
	import buck_pkg::*;

	// Software registers.
	logic [31:0] ctrl0_q;
	logic [31:0] ctrl1_q;
	logic [31:0] ctrl3_q;
	logic [1:0] regctl_q;
	logic [15:0] sleept_q;
	logic [NIRQ-1:0] irq_st_q;
	logic [NIRQ-1:0] irq_msk_q;
	logic [31:0] rdata_q;
	// Sequencer state.
	seq_t state_q;
	logic [7:0] slots_q;
	logic [NOUT-1:0] svalid_q;
	logic [7:0] poll_q;
	logic [7:0] ontime_q;
	logic [LIM_W-1:0] lim_q;
	logic [NOUT-1:0] held_q;
	logic [7:0] hold_q [NOUT];
	logic handover_q;
	logic bus_q;
	logic [15:0] tick_q;
	logic [7:0] bg_q;

	// Field views.
	wire mode_on = ctrl0_q[F_MODE];
	wire hw_handover = ctrl0_q[F_HWHO];
	wire [1:0] poll_sel = ctrl0_q[F_POLL +: 2];
	wire [NOUT-1:0] out_en = ctrl0_q[F_OUTEN +: NOUT];
	wire [15:0] charge_order_field = ctrl0_q[F_ORDER +: 16];
	wire [7:0] switch_on_time_limit = ctrl1_q[F_TLIM +: 8];
	wire [7:0] long_hold = ctrl1_q[F_LONG +: 8];
	wire [7:0] short_hold = ctrl1_q[F_SHORT +: 8];
	wire [7:0] timeout_count_threshold = ctrl3_q[F_TOTH +: 8];
	wire [7:0] charge_count_clear_threshold = ctrl3_q[F_CCTH +: 8];

	// Register decode.
	wire wr_c0 = WR && ADDR == A_CTRL0;
	wire wr_c1 = WR && ADDR == A_CTRL1;
	wire wr_c3 = WR && ADDR == A_CTRL3;
	wire wr_rc = WR && ADDR == A_REGCTL;
	wire wr_st = WR && ADDR == A_SLEEPT;
	wire wr_iq = WR && ADDR == A_IRQST;
	wire wr_mk = WR && ADDR == A_IRQMSK;

	// Requests and polling; each fast-clock interval is rounded up to whole MCLK cycles.
	wire [NOUT-1:0] req = RAIL_LOW & out_en;
	wire [7:0] poll_len = 8'(((POLL_BASE << poll_sel) * CLK_MHZ + FAST_MHZ - 1) / FAST_MHZ);
	wire poll_due = poll_q >= poll_len - 8'h01;
	wire active = mode_on && !handover_q;
	wire [1:0] cur_rail = slots_q[1:0];

	// Sorter result.
	logic [7:0] sorted;
	logic [NOUT-1:0] sorted_v;
	charge_sorter u_sort (
		.REQ(req),
		.ORDER(charge_order_field),
		.SLOTS(sorted),
		.VALID(sorted_v)
	);

	// Switch-on time-out and event counters.
	wire sw_on = state_q == S_CHARGE || state_q == S_DISCH;
	wire to_event = sw_on && (ontime_q == switch_on_time_limit) && switch_on_time_limit != 8'h00;
	wire charge_done = state_q == S_DISCH && CUR_ZERO;
	logic to_hit;
	logic cc_hit;
	wire to_clear = to_hit || cc_hit;
	sat_counter #(.W(8)) u_tocnt (
		.MCLK(MCLK),
		.RST(RST),
		.CLR(to_clear),
		.INC(to_event),
		.THRESH(timeout_count_threshold),
		.COUNT(),
		.HIT(to_hit)
	);
	sat_counter #(.W(8)) u_cccnt (
		.MCLK(MCLK),
		.RST(RST),
		.CLR(cc_hit || to_event),
		.INC(charge_done),
		.THRESH(charge_count_clear_threshold),
		.COUNT(),
		.HIT(cc_hit)
	);

	// Register write side; interrupt clears use write-one, and sets win.
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			ctrl0_q <= 32'({ORDER_RST, 8'h00});
			ctrl1_q <= 32'({SHORT_RST, LONG_RST, TLIM_RST});
			ctrl3_q <= 32'({CCTH_RST, TOTH_RST});
			regctl_q <= 2'h0;
			sleept_q <= 16'h0000;
			irq_msk_q <= '0;
		end
		else
		begin
			if (wr_c0)
				ctrl0_q <= WDATA;
			if (wr_c1)
				ctrl1_q <= WDATA;
			if (wr_c3)
				ctrl3_q <= WDATA;
			if (wr_rc)
				regctl_q <= WDATA[1:0];
			if (wr_st)
				sleept_q <= WDATA[15:0];
			if (wr_mk)
				irq_msk_q <= WDATA[NIRQ-1:0];
		end
	end

	// Sticky event bits; timeout interrupt only when software owns the response.
	wire [NIRQ-1:0] irq_set = {BUS_ABOVE_BAT && !bus_q, to_hit && hw_handover,
		to_hit && !hw_handover};
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			irq_st_q <= '0;
		else
			irq_st_q <= (irq_st_q & ~(wr_iq ? WDATA[NIRQ-1:0] : '0)) | irq_set;
	end
	assign IRQ = |(irq_st_q & irq_msk_q);

	// Read data, one cycle after the strobe; unmapped offsets read zero.
	logic [31:0] rd_mux;
	always_comb
	begin
		case (ADDR)
			A_CTRL0: rd_mux = ctrl0_q;
			A_CTRL1: rd_mux = ctrl1_q;
			A_CTRL3: rd_mux = ctrl3_q;
			A_REGCTL: rd_mux = 32'(regctl_q);
			A_SLEEPT: rd_mux = 32'(sleept_q);
			A_STATUS: rd_mux = 32'({handover_q, lim_q, svalid_q, 3'(state_q)});
			A_IRQST: rd_mux = 32'(irq_st_q);
			A_IRQMSK: rd_mux = 32'(irq_msk_q);
			default: rd_mux = 32'h0;
		endcase
	end
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			rdata_q <= 32'h0;
		else
			rdata_q <= RD ? rd_mux : 32'h0;
	end
	assign RDATA = rdata_q;

	// Charge sequencer.
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			state_q <= S_IDLE;
			slots_q <= 8'h00;
			svalid_q <= '0;
			poll_q <= 8'h00;
			ontime_q <= 8'h00;
		end
		else
		begin
			ontime_q <= sw_on ? ((state_q == S_DISCH && CUR_AT_LIMIT) ? 8'h00 :
				ontime_q + 8'h01) : 8'h00;
			case (state_q)
				S_IDLE:
				begin
					poll_q <= poll_due ? 8'h00 : poll_q + 8'h01;
					if (active && poll_due && |req)
						state_q <= S_LOAD;
				end
				S_LOAD:
				begin
					slots_q <= sorted;
					svalid_q <= sorted_v;
					state_q <= |sorted_v ? S_CHARGE : S_IDLE;
				end
				S_CHARGE:
				begin
					ontime_q <= ontime_q + 8'h01;
					if (CUR_AT_LIMIT || to_event || !active)
					begin
						state_q <= S_DISCH;
						ontime_q <= 8'h00;
					end
				end
				S_DISCH:
					if (CUR_ZERO || to_event)
						state_q <= S_NEXT;
				S_NEXT:
				begin
					slots_q <= slots_q >> 2;
					svalid_q <= svalid_q >> 1;
					state_q <= svalid_q[1] && active ? S_CHARGE : S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// Switch drive; grounded discharge still feeds the selected rail.
	assign SW_BAT = state_q == S_CHARGE;
	assign SW_GND = state_q == S_DISCH;
	assign SW_OUT = sw_on ? NOUT'(1) << cur_rail : '0;

	// Adaptive current limit from each rail's hold time after its charge.
	logic [LIM_W-1:0] lim_d;
	always_comb
	begin
		lim_d = lim_q;
		for (int r = 0; r < NOUT; r++)
		begin
			if (held_q[r] && RAIL_LOW[r] && hold_q[r] < short_hold && lim_q != LIM_MAX)
				lim_d = lim_q + 1'b1;
			else if (held_q[r] && hold_q[r] == long_hold && lim_q != '0 && lim_d == lim_q)
				lim_d = lim_q - 1'b1;
		end
	end
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			lim_q <= LIM_RST;
			held_q <= '0;
			for (int r = 0; r < NOUT; r++)
				hold_q[r] <= 8'h00;
		end
		else
		begin
			if (active)
				lim_q <= lim_d;
			for (int r = 0; r < NOUT; r++)
			begin
				if (charge_done && cur_rail == 2'(r))
				begin
					held_q[r] <= 1'b1;
					hold_q[r] <= 8'h00;
				end
				else if (held_q[r])
				begin
					hold_q[r] <= hold_q[r] + 8'h01;
					if (RAIL_LOW[r] || hold_q[r] == long_hold)
						held_q[r] <= 1'b0;
				end
			end
		end
	end
	assign CUR_LIMIT = lim_q;

	// Linear hand-over latch, released when software rewrites the mode.
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			handover_q <= 1'b0;
			bus_q <= 1'b0;
		end
		else
		begin
			bus_q <= BUS_ABOVE_BAT;
			if (to_hit && hw_handover)
				handover_q <= 1'b1;
			else if (wr_c0)
				handover_q <= 1'b0;
		end
	end
	assign LINEAR_HANDOVER = handover_q;
	assign BUS_REG_EN = bus_q;
	assign HOLD_REG_ACTIVE = regctl_q[0];

	// Bandgap refresh: after the programmed tick count, power up and sample.
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			tick_q <= 16'h0000;
			bg_q <= 8'h00;
		end
		else if (sleept_q == 16'h0000)
		begin
			tick_q <= 16'h0000;
			bg_q <= 8'h00;
		end
		else
		begin
			if (SLEEP_TICK)
				tick_q <= (tick_q >= sleept_q - 16'h0001) ? 16'h0000 : tick_q + 16'h0001;
			if (SLEEP_TICK && tick_q >= sleept_q - 16'h0001)
				bg_q <= BG_ON_CYC;
			else if (bg_q != 8'h00)
				bg_q <= bg_q - 8'h01;
		end
	end
	assign BANDGAP_EN = bg_q != 8'h00;
	assign HOLD_SAMPLE = bg_q == 8'h01;
endmodule

// file: hw/charge_sorter.sv
// Builds the four-slot charge order from requests and the order field.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module charge_sorter
	import buck_pkg::*;
(
	// Inputs.
	input wire logic [NOUT-1:0] REQ,
	input wire logic [15:0] ORDER,
	// Outputs: slot list in service order, with slot valid bits.
	output logic [7:0] SLOTS,
	output logic [NOUT-1:0] VALID
);
	// Walk the priority positions and compact the requesting rails to the front.
	always_comb
	begin
		int n;
		logic [1:0] rail;
		n = 0;
		rail = 2'h0;
		SLOTS = 8'h00;
		VALID = '0;
		for (int p = 0; p < NOUT; p++)
		begin
			rail = ORDER[p*2 +: 2];
			if (REQ[rail])
			begin
				SLOTS[n*2 +: 2] = rail;
				VALID[n] = 1'b1;
				n = n + 1;
			end
		end
	end
endmodule

// file: hw/sat_counter.sv
// Saturating up counter with synchronous clear and a threshold compare.
// Assumes a single clock and asynchronous active-high reset.
`timescale 1ns/1ps
module sat_counter #(parameter int W = 8)
(
	// Clock and reset.
	input wire logic MCLK,
	input wire logic RST,
	// Control.
	input wire logic CLR,
	input wire logic INC,
	input wire logic [W-1:0] THRESH,
	// Result.
	output logic [W-1:0] COUNT,
	output logic HIT
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	// Clear wins so that a restart is never overtaken by an increment.
	assign cnt_d = CLR ? '0 : (INC && cnt_q != '1) ? cnt_q + 1'b1 : cnt_q;
	assign COUNT = cnt_q;
	// A zero threshold never fires, which keeps an unprogrammed limit harmless.
	assign HIT = (THRESH != '0) && (cnt_q >= THRESH);
	// Count register.
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end
endmodule

// file: include/buck_pkg.sv
// Constants, register map and state types for the four-output buck sequencer.
// Assumes a single 10 MHz clock and a plain register port with one-cycle read latency.
package buck_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int NOUT = 4;
	localparam int LIM_W = 5;
	// Register offsets.
	localparam logic [ADDR_W-1:0] A_CTRL0 = 4'h0;
	localparam logic [ADDR_W-1:0] A_CTRL1 = 4'h1;
	localparam logic [ADDR_W-1:0] A_CTRL3 = 4'h2;
	localparam logic [ADDR_W-1:0] A_REGCTL = 4'h3;
	localparam logic [ADDR_W-1:0] A_SLEEPT = 4'h4;
	localparam logic [ADDR_W-1:0] A_STATUS = 4'h5;
	localparam logic [ADDR_W-1:0] A_IRQST = 4'h6;
	localparam logic [ADDR_W-1:0] A_IRQMSK = 4'h7;
	// Control 0 field layout.
	localparam int F_MODE = 0;
	localparam int F_HWHO = 1;
	localparam int F_POLL = 2;
	localparam int F_OUTEN = 4;
	localparam int F_ORDER = 8;
	// Control 1 and 3 layouts.
	localparam int F_TLIM = 0;
	localparam int F_LONG = 8;
	localparam int F_SHORT = 16;
	localparam int F_TOTH = 0;
	localparam int F_CCTH = 8;
	// Reset values.
	localparam logic [15:0] ORDER_RST = 16'hE4;
	localparam logic [7:0] TLIM_RST = 8'h40;
	localparam logic [7:0] LONG_RST = 8'hC8;
	localparam logic [7:0] SHORT_RST = 8'h04;
	localparam logic [7:0] TOTH_RST = 8'h08;
	localparam logic [7:0] CCTH_RST = 8'h10;
	localparam logic [LIM_W-1:0] LIM_RST = 5'h10;
	localparam logic [LIM_W-1:0] LIM_MAX = 5'h1F;
	// Interrupt status bits.
	localparam int IRQ_TO = 0;
	localparam int IRQ_HO = 1;
	localparam int IRQ_BUS = 2;
	localparam int NIRQ = 3;
	// Poll interval base: 2 cycles of the 16 MHz clock in the 10 MHz domain.
	localparam int FAST_MHZ = 16;
	localparam int CLK_MHZ = 10;
	localparam int POLL_BASE = 2;
	localparam int POLL_CYC = (POLL_BASE * CLK_MHZ + FAST_MHZ - 1) / FAST_MHZ;
	// Bandgap sample window in clocks.
	localparam logic [7:0] BG_ON_CYC = 8'h08;
	typedef enum logic [2:0] {S_IDLE, S_LOAD, S_CHARGE, S_DISCH, S_NEXT} seq_t;
endpackage

// file: verification/buck_props.sv
// Port checks for the buck charge sequencer.
// Assumes the single MCLK domain; bound onto every sequencer instance below.
`timescale 1ns/1ps
module buck_props
	import buck_pkg::*;
(
	// Clock, reset and register port.
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [buck_pkg::ADDR_W-1:0] ADDR,
	input wire logic [buck_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	// Sense inputs.
	input wire logic CUR_AT_LIMIT,
	input wire logic CUR_ZERO,
	input wire logic BUS_ABOVE_BAT,
	// Outputs under watch.
	input wire logic SW_BAT,
	input wire logic SW_GND,
	input wire logic [buck_pkg::NOUT-1:0] SW_OUT,
	input wire logic [buck_pkg::LIM_W-1:0] CUR_LIMIT,
	input wire logic BUS_REG_EN,
	input wire logic HOLD_REG_ACTIVE,
	input wire logic BANDGAP_EN,
	input wire logic HOLD_SAMPLE,
	input wire logic IRQ
);
	// Every check runs on MCLK and sleeps through reset.
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);
	// The bandgap window is eight cycles, then off.
	sequence bg_window;
		BANDGAP_EN [*8] ##1 !BANDGAP_EN;
	endsequence
	// Discharge step: ground switch on, battery switch off.
	sequence disch_step;
		SW_GND && !SW_BAT;
	endsequence
	a_charge_one_out: assert property (SW_BAT |-> $onehot(SW_OUT))
		else $error("charge drives other than one output");
	a_limit_to_disch: assert property (SW_BAT && CUR_AT_LIMIT |=> disch_step)
		else $error("limit reached without discharge");
	a_no_short: assert property (!(SW_BAT && SW_GND))
		else $error("battery and ground switch on together");
	a_disch_hold: assert property (SW_GND && !CUR_ZERO |=> SW_GND)
		else $error("discharge left before zero current");
	a_limit_step: assert property ($changed(CUR_LIMIT) |->
		CUR_LIMIT == 5'($past(CUR_LIMIT) + 5'h01) ||
		CUR_LIMIT == 5'($past(CUR_LIMIT) - 5'h01))
		else $error("current limit moved by more than one step");
	a_irq_hold: assert property (IRQ && !WR |=> IRQ)
		else $error("interrupt dropped without a write");
	a_bus_reg_on: assert property ($rose(BUS_ABOVE_BAT) |=> BUS_REG_EN)
		else $error("bus regulator not enabled");
	a_hold_reg_on: assert property (WR && ADDR == A_REGCTL && WDATA[0] |=> HOLD_REG_ACTIVE)
		else $error("hold regulator not kept active");
	a_bandgap_len: assert property ($rose(BANDGAP_EN) |-> bg_window)
		else $error("bandgap window length wrong");
	a_sample_last: assert property (HOLD_SAMPLE |-> BANDGAP_EN ##1 !BANDGAP_EN)
		else $error("sample not on last bandgap cycle");
endmodule
bind buck_sequencer buck_props props_u (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .CUR_AT_LIMIT(CUR_AT_LIMIT), .CUR_ZERO(CUR_ZERO), .BUS_ABOVE_BAT(BUS_ABOVE_BAT),
	.SW_BAT(SW_BAT), .SW_GND(SW_GND), .SW_OUT(SW_OUT), .CUR_LIMIT(CUR_LIMIT),
	.BUS_REG_EN(BUS_REG_EN), .HOLD_REG_ACTIVE(HOLD_REG_ACTIVE), .BANDGAP_EN(BANDGAP_EN),
	.HOLD_SAMPLE(HOLD_SAMPLE), .IRQ(IRQ));

// file: verification/buck_sequencer_bench.sv
// Self-checking bench for the buck charge sequencer.
// Assumes the package register map and an inductor model on the sense inputs.
`timescale 1ns/1ps
module buck_sequencer_bench;
	import buck_pkg::*;
	logic MCLK = 1'b0;
	logic RST = 1'b1;
	logic [ADDR_W-1:0] ADDR = '0;
	logic [DATA_W-1:0] WDATA = '0;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic [NOUT-1:0] RAIL_LOW = '0;
	logic BUS_ABOVE_BAT = 1'b0;
	logic SLEEP_TICK = 1'b0;
	logic stall = 1'b0; // Model never reaches the limit while set.
	logic bg_seen = 1'b0; // Set once any bandgap window shows.
	logic [DATA_W-1:0] RDATA, rv;
	logic CUR_AT_LIMIT, CUR_ZERO, SW_BAT, SW_GND, LINEAR_HANDOVER, BUS_REG_EN;
	logic HOLD_REG_ACTIVE, BANDGAP_EN, HOLD_SAMPLE, IRQ;
	logic [NOUT-1:0] SW_OUT;
	logic [LIM_W-1:0] CUR_LIMIT, lim_ref;
	logic [DATA_W-1:0] ctl0 = (32'(ORDER_RST) << F_ORDER) | 32'hF1; // All rails, active.
	int error_cnt = 0;
	int comparisons = 0;
	buck_sequencer dut_u (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .RAIL_LOW(RAIL_LOW), .CUR_AT_LIMIT(CUR_AT_LIMIT),
		.CUR_ZERO(CUR_ZERO), .BUS_ABOVE_BAT(BUS_ABOVE_BAT), .SLEEP_TICK(SLEEP_TICK),
		.SW_BAT(SW_BAT), .SW_GND(SW_GND), .SW_OUT(SW_OUT), .CUR_LIMIT(CUR_LIMIT),
		.LINEAR_HANDOVER(LINEAR_HANDOVER), .BUS_REG_EN(BUS_REG_EN),
		.HOLD_REG_ACTIVE(HOLD_REG_ACTIVE), .BANDGAP_EN(BANDGAP_EN),
		.HOLD_SAMPLE(HOLD_SAMPLE), .IRQ(IRQ));
	inductor_model model_u (.mclk(MCLK), .rst(RST), .sw_bat(SW_BAT), .sw_gnd(SW_GND),
		.stall(stall), .cur_at_limit(CUR_AT_LIMIT), .cur_zero(CUR_ZERO));
	// Free-running 10 MHz clock.
	always #50 MCLK = ~MCLK;
	// A window may end between samples, so it is latched here.
	always @(posedge MCLK)
		if (BANDGAP_EN === 1'b1)
			bg_seen <= 1'b1;
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge MCLK);
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge MCLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge MCLK);
		WR <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe; they are taken at the edge that closes it.
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge MCLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge MCLK);
		RD <= 1'b0;
		@(posedge MCLK);
		rv = RDATA;
	endtask
	function automatic logic probe(input int s);
		case (s)
			0: return SW_BAT;
			1: return SW_GND;
			2: return IRQ;
			3: return LINEAR_HANDOVER;
			default: return CUR_LIMIT !== lim_ref;
		endcase
	endfunction
	// Bounded wait; the comparison after it catches a miss.
	task automatic await(input int s, input int n);
		for (int k = 0; k < n && probe(s) !== 1'b1; k++)
			cyc(1);
	endtask
	task automatic t_reset;
		rd(A_CTRL0);
		chk("ctrl0", rv, 32'(ORDER_RST) << F_ORDER);
		rd(A_CTRL1);
		chk("ctrl1", rv, {8'h00, SHORT_RST, LONG_RST, TLIM_RST});
		rd(A_CTRL3);
		chk("ctrl3", rv, {16'h0000, CCTH_RST, TOTH_RST});
		rd(4'h8);
		chk("unmapped", rv, 32'h0);
		chk("limit", 32'(CUR_LIMIT), 32'(LIM_RST));
	endtask
	// Two rails low at once, served in order, then the limit adapts both ways.
	task automatic t_order;
		wr(A_CTRL0, ctl0);
		RAIL_LOW <= 4'hA;
		await(0, 100);
		chk("first out", 32'(SW_OUT), 32'h2);
		await(1, 100);
		chk("discharge", 32'(SW_GND), 32'h1);
		await(0, 100);
		chk("second out", 32'(SW_OUT), 32'h8);
		lim_ref = LIM_RST;
		await(5, 3000);
		chk("limit up", 32'(CUR_LIMIT), 32'(LIM_RST) + 32'h1);
		// The last rail now stays up long enough for the limit to step back down.
		RAIL_LOW <= 4'h0;
		lim_ref = LIM_RST + 5'h01;
		await(5, 400);
		chk("limit down", 32'(CUR_LIMIT), 32'(LIM_RST));
		cyc(50);
	endtask
	// Stuck switch: interrupt first, then hardware hand-over.
	task automatic t_timeout;
		wr(A_CTRL1, {8'h00, SHORT_RST, LONG_RST, 8'h04});
		wr(A_CTRL3, {16'h0000, 8'h01, 8'h02});
		wr(A_IRQMSK, 32'h1);
		stall <= 1'b1;
		RAIL_LOW <= 4'h1;
		// Each stuck charge is followed by a charge event, so the count never reaches two.
		cyc(100);
		chk("stress cleared", 32'(IRQ), 32'h0);
		wr(A_CTRL3, {16'h0000, CCTH_RST, 8'h01});
		await(2, 200);
		chk("irq", 32'(IRQ), 32'h1);
		rd(A_IRQST);
		chk("timeout bit", 32'(rv[IRQ_TO]), 32'h1);
		stall <= 1'b0;
		RAIL_LOW <= 4'h0;
		cyc(20);
		chk("irq held", 32'(IRQ), 32'h1);
		wr(A_IRQST, 32'h1);
		cyc(1);
		chk("irq cleared", 32'(IRQ), 32'h0);
		wr(A_CTRL0, ctl0 | 32'h2);
		stall <= 1'b1;
		RAIL_LOW <= 4'h1;
		await(3, 200);
		chk("handover", 32'(LINEAR_HANDOVER), 32'h1);
		rd(A_IRQST);
		chk("handover bit", 32'(rv[IRQ_HO]), 32'h1);
		stall <= 1'b0;
		RAIL_LOW <= 4'h0;
		wr(A_CTRL0, ctl0);
	endtask
	// Bus regulator, hold regulator and bandgap refresh.
	task automatic t_regs;
		BUS_ABOVE_BAT <= 1'b1;
		cyc(2);
		chk("bus reg", 32'(BUS_REG_EN), 32'h1);
		rd(A_IRQST);
		chk("bus bit", 32'(rv[IRQ_BUS]), 32'h1);
		// Regulators are enabled before the converter is switched off.
		wr(A_REGCTL, 32'h3);
		cyc(1);
		chk("hold reg", 32'(HOLD_REG_ACTIVE), 32'h1);
		rd(A_REGCTL);
		chk("regctl", rv, 32'h3);
		wr(A_CTRL0, ctl0 & ~32'h1);
		cyc(1);
		chk("hold kept", 32'(HOLD_REG_ACTIVE), 32'h1);
		wr(A_SLEEPT, 32'h2);
		repeat (2)
		begin
			@(posedge MCLK);
			SLEEP_TICK <= 1'b1;
			@(posedge MCLK);
			SLEEP_TICK <= 1'b0;
		end
		// The second tick loads the window; its last cycle carries the sample strobe.
		cyc(8);
		chk("sample", 32'(HOLD_SAMPLE), 32'h1);
		cyc(1);
		chk("bandgap off", 32'(BANDGAP_EN), 32'h0);
		chk("bandgap", 32'(bg_seen), 32'h1);
		// A zero interval must keep the bandgap asleep whatever the ticks do.
		wr(A_SLEEPT, 32'h0);
		repeat (2)
		begin
			@(posedge MCLK);
			SLEEP_TICK <= 1'b1;
			@(posedge MCLK);
			SLEEP_TICK <= 1'b0;
		end
		cyc(2);
		chk("no refresh", 32'(BANDGAP_EN), 32'h0);
	endtask
	task automatic wrap_up;
		if (error_cnt == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Main sequence after a five-cycle reset.
	initial
	begin
		repeat (5) @(posedge MCLK);
		RST <= 1'b0;
		t_reset();
		t_order();
		t_timeout();
		t_regs();
		wrap_up();
	end
	// Watchdog well beyond the expected few hundred cycles.
	initial
	begin
		#3000000;
		error_cnt++;
		wrap_up();
	end
endmodule

// file: verification/inductor_model.sv
// Behavioural inductor and current sense seen by the sequencer.
// Assumes the switch controls are synchronous to the same clock.
`timescale 1ns/1ps
module inductor_model
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Switch states.
	input wire logic sw_bat,
	input wire logic sw_gnd,
	// Keeps the current from rising, which forces a switch time-out.
	input wire logic stall,
	// Current sense.
	output logic cur_at_limit,
	output logic cur_zero
);
	logic [3:0] level_q; // Inductor current in arbitrary steps.
	// Current ramps on the battery switch and decays on the ground switch.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			level_q <= 4'h0;
		else if (sw_bat && !stall && level_q != 4'hF)
			level_q <= level_q + 4'h1;
		else if (sw_gnd && level_q != 4'h0)
			level_q <= level_q - 4'h1;
	end
	assign cur_at_limit = (level_q >= 4'h3);
	assign cur_zero = (level_q == 4'h0);
endmodule
